// File: src/ppp_cfg.svh
// Purpose: Constants of the parallel programming port.
// Assumes: A 25 MHz system clock.
// Notes: Reset values stand for the shipped state of the fuses and locks.
`ifndef PPP_CFG_SVH
`define PPP_CFG_SVH

`define PPP_CLK_PERIOD_NS 40
// Programming time of one byte, typical figure.
`define PPP_WR_TIME_NS 700000
`define PPP_WR_CYC (`PPP_WR_TIME_NS / `PPP_CLK_PERIOD_NS)

`define PPP_ACT_ADDR 2'h0
`define PPP_ACT_DATA 2'h1
`define PPP_ACT_CMD 2'h2
`define PPP_ACT_IDLE 2'h3

`define PPP_FLASH_AW 12
`define PPP_EE_AW 9
`define PPP_EE_WORDS 13'h0200
`define PPP_FLASH_WORDS 13'h1000

`define PPP_LOCK_RST 1'h1
`define PPP_SERIAL_DOWNLOAD_FUSE_RST 1'h0
`define PPP_QUICK_STARTUP_FUSE_RST 1'h1

// Bit positions in the fuse and lock data bytes.
`define PPP_FUSE_SERIAL_DOWNLOAD_FUSE_BIT 5
`define PPP_FUSE_QUICK_STARTUP_FUSE_BIT 0
`define PPP_LOCKW_LB2_BIT 2
`define PPP_LOCKW_LB1_BIT 1
`define PPP_ERASED_BYTE 8'hFF
`define PPP_LOCKED_READ 8'hFF

// Identification bytes; the values are arbitrary.
`define PPP_ID0 8'hA5
`define PPP_ID1 8'h5A
`define PPP_ID2 8'h3C

`endif

// File: src/ppp_pkg.sv
// Purpose: Types of the parallel programming port.
// Assumes: Nothing beyond the constants header.
// Notes: Command codes are the full command byte.
package ppp_pkg;

    typedef enum logic [7:0] {
        CMD_CHIP_ERASE = 8'h80,
        CMD_WR_FUSE = 8'h40,
        CMD_WR_LOCK = 8'h20,
        CMD_WR_FLASH = 8'h10,
        CMD_WR_EE = 8'h11,
        CMD_RD_SIG = 8'h08,
        CMD_RD_LOCKFUSE = 8'h04,
        CMD_RD_FLASH = 8'h02,
        CMD_RD_EE = 8'h03
    } ppp_cmd_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PROG = 2'b01,
        ST_ERASE = 2'b10
    } ppp_state_t;

endpackage

// File: src/ppp_mem_if.sv
// Purpose: Port bundle between the controller and one memory array.
// Assumes: Byte-wide arrays.
// Notes: Read data arrive one clock after the address.
`timescale 1ns/100ps
interface ppp_mem_if #(parameter int AW = 12);
    logic [AW-1:0] addr;
    logic [7:0] wdata;
    logic we;
    logic [7:0] rdata;
    modport ctrl (output addr, output wdata, output we, input rdata);
    modport mem (input addr, input wdata, input we, output rdata);
endinterface

// File: src/ppp_mem.sv
// Purpose: Byte-wide array with a registered read port.
// Assumes: One write or read per clock.
// Notes: Contents are undefined until the first chip erase.
`timescale 1ns/100ps
module ppp_mem #(parameter int AW = 12) (
    input wire logic clk_sys,
    ppp_mem_if.mem port
);
    logic [7:0] store [0:(1<<AW)-1];

    always_ff @(posedge clk_sys) begin
        if (port.we) begin
            store[port.addr] <= port.wdata;
        end
        port.rdata <= store[port.addr];
    end
endmodule

// File: src/ppp_top.sv
// Purpose: Parallel programming port with its arrays, locks and fuses.
// Assumes: All pins are synchronous to clk_sys; high-voltage entry is done.
// Notes: Chip erase walks every address, so it takes 4096 clocks.
`timescale 1ns/100ps
`include "ppp_cfg.svh"

// Function
// - Two lock bits give three modes: open, write-blocked, read-blocked.
// - Lock bits return to unprogrammed only through chip erase.
// - Once protection is active, fuse writes are refused.
// - Serial download allowed while its fuse reads zero; default zero.
// - Start-up fuse zero selects short delay; default one.
// - Three identification bytes at addresses zero to two.
// - Serial reads under full lock return 00, 01, 02.
// - Ready output low while programming, high when ready.
// - Data bus driven only while output enable is low.
// - Byte select zero picks low byte, one picks high byte.
// - Load pulse acts on action code: address, data, command, nothing.
// - Strobes act according to the last loaded command.
// - Command byte decoding of erase, writes and reads.
// - Erase clears both arrays, then locks; fuses stay.
// - Erase is a loaded command plus a strobe falling edge of any length; ready untouched.
// - Write strobe starts byte programming and drops ready.
// - Command and address are kept across operations.
// - Flash read: select zero gives low byte, one gives high.
// - Fuse data bit 5 serial fuse, bit 0 start-up fuse.
module ppp_top #(
    parameter int WR_CYC = `PPP_WR_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic load_pulse_pin,
    input wire logic action_code_low,
    input wire logic action_code_high,
    input wire logic byte_choice,
    input wire logic wr_n,
    input wire logic oe_n,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic op_progress_flag,
    input wire logic [1:0] ser_sig_addr,
    output logic [7:0] ser_sig_data,
    output logic serial_download_en,
    output logic quick_startup_sel,
    output logic [1:0] protect_mode
);

    function automatic logic [7:0] ppp_sig(input logic [1:0] idx);
        case (idx)
            2'h0: ppp_sig = `PPP_ID0;
            2'h1: ppp_sig = `PPP_ID1;
            2'h2: ppp_sig = `PPP_ID2;
            default: ppp_sig = `PPP_ERASED_BYTE;
        endcase
    endfunction

    // Inputs and edges.
    logic load_prev_q;
    logic wr_prev_q;
    logic load_rise;
    logic wr_fall;

    // Loaded values, kept across operations.
    logic [7:0] cmd_q;
    logic [3:0] addr_hi_q;
    logic [7:0] addr_lo_q;
    logic [7:0] dat_lo_q;
    logic [7:0] dat_hi_q;

    // Nonvolatile bits; zero means programmed.
    logic lb1_q;
    logic lb2_q;
    logic serial_download_fuse_q;
    logic quick_startup_fuse_q;
    // Enabled-sense copies, so these pins come straight from flip-flops.
    logic sd_q;
    logic qs_q;

    ppp_pkg::ppp_state_t state_q;
    ppp_pkg::ppp_state_t state_d;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;

    logic [7:0] data_out_q;
    logic data_oe_q;
    logic ready_q;
    logic [7:0] ser_sig_q;

    // Command decode.
    logic is_erase;
    logic is_wr_fuse;
    logic is_wr_lock;
    logic is_wr_flash;
    logic is_wr_ee;
    logic is_rd_sig;
    logic is_rd_lf;
    logic is_rd_flash;
    logic is_rd_ee;
    logic wr_blocked;
    logic rd_blocked;
    logic idle;
    logic start_prog;
    logic start_erase;
    logic erase_last;
    logic erase_ee;
    logic [1:0] action;
    logic [11:0] addr_full;
    logic [7:0] lf_byte;
    logic [7:0] rd_byte;

    ppp_mem_if #(.AW(`PPP_FLASH_AW)) fl_lo ();
    ppp_mem_if #(.AW(`PPP_FLASH_AW)) fl_hi ();
    ppp_mem_if #(.AW(`PPP_EE_AW)) ee ();

    assign load_rise = load_pulse_pin & ~load_prev_q;
    assign wr_fall = ~wr_n & wr_prev_q;
    assign action = {action_code_high, action_code_low};

    assign is_erase = cmd_q == ppp_pkg::CMD_CHIP_ERASE;
    assign is_wr_fuse = cmd_q == ppp_pkg::CMD_WR_FUSE;
    assign is_wr_lock = cmd_q == ppp_pkg::CMD_WR_LOCK;
    assign is_wr_flash = cmd_q == ppp_pkg::CMD_WR_FLASH;
    assign is_wr_ee = cmd_q == ppp_pkg::CMD_WR_EE;
    assign is_rd_sig = cmd_q == ppp_pkg::CMD_RD_SIG;
    assign is_rd_lf = cmd_q == ppp_pkg::CMD_RD_LOCKFUSE;
    assign is_rd_flash = cmd_q == ppp_pkg::CMD_RD_FLASH;
    assign is_rd_ee = cmd_q == ppp_pkg::CMD_RD_EE;

    // Any programmed lock stops array and fuse writes; both stop verification reads.
    assign wr_blocked = ~lb1_q | ~lb2_q;
    assign rd_blocked = ~lb1_q & ~lb2_q;

    assign idle = state_q == ppp_pkg::ST_IDLE;
    // A strobe during an operation is ignored rather than queued.
    assign start_prog = idle & wr_fall & ~wr_blocked
                        & (is_wr_flash | is_wr_ee);
    assign start_erase = idle & wr_fall & is_erase;
    assign erase_last = cnt_q[11:0] == 12'hFFF;
    assign erase_ee = cnt_q[15:9] == 7'h00;

    assign addr_full = {addr_hi_q, addr_lo_q};

    // Memory steering: the erase walker owns the arrays while it runs.
    always_comb begin
        fl_lo.addr = addr_full;
        fl_hi.addr = addr_full;
        ee.addr = addr_full[8:0];
        fl_lo.wdata = dat_lo_q;
        fl_hi.wdata = dat_hi_q;
        ee.wdata = dat_lo_q;
        fl_lo.we = 1'b0;
        fl_hi.we = 1'b0;
        ee.we = 1'b0;
        if (state_q == ppp_pkg::ST_ERASE) begin
            fl_lo.addr = cnt_q[11:0];
            fl_hi.addr = cnt_q[11:0];
            ee.addr = cnt_q[8:0];
            fl_lo.wdata = `PPP_ERASED_BYTE;
            fl_hi.wdata = `PPP_ERASED_BYTE;
            ee.wdata = `PPP_ERASED_BYTE;
            fl_lo.we = 1'b1;
            fl_hi.we = 1'b1;
            ee.we = erase_ee;
        end else if (start_prog) begin
            fl_lo.we = is_wr_flash & ~byte_choice;
            fl_hi.we = is_wr_flash & byte_choice;
            ee.we = is_wr_ee;
        end
    end

    ppp_mem #(.AW(`PPP_FLASH_AW)) u_fl_lo (
        .clk_sys(clk_sys),
        .port(fl_lo)
    );
    ppp_mem #(.AW(`PPP_FLASH_AW)) u_fl_hi (
        .clk_sys(clk_sys),
        .port(fl_hi)
    );
    ppp_mem #(.AW(`PPP_EE_AW)) u_ee (
        .clk_sys(clk_sys),
        .port(ee)
    );

    // Lock and fuse status byte; reserved bits read as one.
    assign lf_byte = {lb1_q, lb2_q, serial_download_fuse_q, 4'hF, quick_startup_fuse_q};

    // Read data selection by command and byte select.
    always_comb begin
        rd_byte = `PPP_ERASED_BYTE;
        if (is_rd_flash) begin
            rd_byte = byte_choice ? fl_hi.rdata : fl_lo.rdata;
            if (rd_blocked) begin
                rd_byte = `PPP_LOCKED_READ;
            end
        end else if (is_rd_ee) begin
            rd_byte = rd_blocked ? `PPP_LOCKED_READ : ee.rdata;
        end else if (is_rd_sig) begin
            rd_byte = ppp_sig(addr_lo_q[1:0]);
            if (addr_lo_q[7:2] != 6'h00) begin
                rd_byte = `PPP_ERASED_BYTE;
            end
        end else if (is_rd_lf & byte_choice) begin
            rd_byte = lf_byte;
        end
    end

    // Sequencer for byte programming and chip erase.
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            ppp_pkg::ST_IDLE: begin
                if (start_erase) begin
                    state_d = ppp_pkg::ST_ERASE;
                    cnt_d = 16'h0000;
                end else if (start_prog) begin
                    state_d = ppp_pkg::ST_PROG;
                    cnt_d = 16'(WR_CYC - 1);
                end
            end
            ppp_pkg::ST_PROG: begin
                if (cnt_q == 16'h0000) begin
                    state_d = ppp_pkg::ST_IDLE;
                end else begin
                    cnt_d = cnt_q - 16'h0001;
                end
            end
            ppp_pkg::ST_ERASE: begin
                if (erase_last) begin
                    state_d = ppp_pkg::ST_IDLE;
                end
                cnt_d = cnt_q + 16'h0001;
            end
            default: begin
                state_d = ppp_pkg::ST_IDLE;
                cnt_d = 16'h0000;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= ppp_pkg::ST_IDLE;
            cnt_q <= 16'h0000;
            load_prev_q <= 1'b0;
            wr_prev_q <= 1'b1;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            load_prev_q <= load_pulse_pin;
            wr_prev_q <= wr_n;
        end
    end

    // Loading on the load pulse edge.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cmd_q <= 8'h00;
            addr_hi_q <= 4'h0;
            addr_lo_q <= 8'h00;
            dat_lo_q <= 8'hFF;
            dat_hi_q <= 8'hFF;
        end else if (load_rise) begin
            case (action)
                `PPP_ACT_ADDR: begin
                    if (byte_choice) begin
                        addr_hi_q <= data_in[3:0];
                    end else begin
                        addr_lo_q <= data_in;
                    end
                end
                `PPP_ACT_DATA: begin
                    if (byte_choice) begin
                        dat_hi_q <= data_in;
                    end else begin
                        dat_lo_q <= data_in;
                    end
                end
                `PPP_ACT_CMD: cmd_q <= data_in;
                default: cmd_q <= cmd_q;
            endcase
        end
    end

    // Locks and fuses. Fuse and lock writes act at once with no busy time.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lb1_q <= `PPP_LOCK_RST;
            lb2_q <= `PPP_LOCK_RST;
            serial_download_fuse_q <= `PPP_SERIAL_DOWNLOAD_FUSE_RST;
            quick_startup_fuse_q <= `PPP_QUICK_STARTUP_FUSE_RST;
            sd_q <= ~`PPP_SERIAL_DOWNLOAD_FUSE_RST;
            qs_q <= ~`PPP_QUICK_STARTUP_FUSE_RST;
        end else if (state_q == ppp_pkg::ST_ERASE) begin
            // Locks are released only once both arrays are blank.
            if (erase_last) begin
                lb1_q <= 1'b1;
                lb2_q <= 1'b1;
            end
        end else if (idle & wr_fall & ~byte_choice) begin
            if (is_wr_lock) begin
                // A write can only program a lock, never release it.
                lb1_q <= lb1_q & dat_lo_q[`PPP_LOCKW_LB1_BIT];
                lb2_q <= lb2_q & dat_lo_q[`PPP_LOCKW_LB2_BIT];
            end else if (is_wr_fuse & ~wr_blocked) begin
                serial_download_fuse_q <= dat_lo_q[`PPP_FUSE_SERIAL_DOWNLOAD_FUSE_BIT];
                quick_startup_fuse_q <= dat_lo_q[`PPP_FUSE_QUICK_STARTUP_FUSE_BIT];
                sd_q <= ~dat_lo_q[`PPP_FUSE_SERIAL_DOWNLOAD_FUSE_BIT];
                qs_q <= ~dat_lo_q[`PPP_FUSE_QUICK_STARTUP_FUSE_BIT];
            end
        end
    end

    // Pin outputs, all registered.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            data_out_q <= 8'h00;
            data_oe_q <= 1'b0;
            ready_q <= 1'b1;
            ser_sig_q <= 8'h00;
        end else begin
            data_oe_q <= ~oe_n;
            data_out_q <= oe_n ? 8'h00 : rd_byte;
            ready_q <= state_d != ppp_pkg::ST_PROG;
            if (rd_blocked) begin
                ser_sig_q <= {6'h00, ser_sig_addr};
            end else begin
                ser_sig_q <= ppp_sig(ser_sig_addr);
            end
        end
    end

    assign data_out = data_out_q;
    assign data_oe = data_oe_q;
    assign op_progress_flag = ready_q;
    assign ser_sig_data = ser_sig_q;
    assign serial_download_en = sd_q;
    assign quick_startup_sel = qs_q;
    assign protect_mode = {lb2_q, lb1_q};

endmodule

// File: testbench/ppp_top_monitor.sv
// Purpose: Port checks of the parallel programming port.
// Assumes: Sees only the top module's ports.
// Notes: WR_CYC must match the instance under test.
`timescale 1ns/100ps
`include "ppp_cfg.svh"
module ppp_monitor #(
    parameter int WR_CYC = 20
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wr_n,
    input wire logic oe_n,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    input wire logic op_progress_flag,
    input wire logic [1:0] ser_sig_addr,
    input wire logic [7:0] ser_sig_data,
    input wire logic serial_download_en,
    input wire logic quick_startup_sel,
    input wire logic [1:0] protect_mode
);
    logic [15:0] low_q;
    logic [15:0] low_d;
    wire [7:0] id_sel = (ser_sig_addr == 2'h0) ? `PPP_ID0 :
        (ser_sig_addr == 2'h1) ? `PPP_ID1 : `PPP_ID2;
    assign low_d = op_progress_flag ? 16'h0000 : low_q + 16'h0001;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            low_q <= 16'h0000;
        end else begin
            low_q <= low_d;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_oe_drive;
        $fell(oe_n) |=> data_oe;
    endproperty
    a_oe_drive: assert property (p_oe_drive)
        else $error("bus not driven after output enable");
    property p_oe_off;
        oe_n |=> !data_oe && data_out == 8'h00;
    endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("bus driven without output enable");
    property p_busy_cause;
        $fell(op_progress_flag) |-> !$past(wr_n) && $past(wr_n, 2);
    endproperty
    a_busy_cause: assert property (p_busy_cause)
        else $error("busy without a write strobe");
    property p_busy_len;
        $rose(op_progress_flag) |-> low_q == WR_CYC;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("busy time wrong");
    property p_sig_open;
        protect_mode != 2'h0 && ser_sig_addr <= 2'h2
            |=> ser_sig_data == $past(id_sel);
    endproperty
    a_sig_open: assert property (p_sig_open)
        else $error("serial id byte wrong");
    property p_sig_locked;
        protect_mode == 2'h0 && ser_sig_addr <= 2'h2
            |=> ser_sig_data == {6'h00, $past(ser_sig_addr)};
    endproperty
    a_sig_locked: assert property (p_sig_locked)
        else $error("locked serial id byte wrong");
    property p_lock_clear;
        |(protect_mode & ~$past(protect_mode)) |-> protect_mode == 2'h3;
    endproperty
    a_lock_clear: assert property (p_lock_clear)
        else $error("single lock bit cleared");
    property p_fuse_frozen;
        $changed({serial_download_en, quick_startup_sel})
            |-> $past(protect_mode) == 2'h3;
    endproperty
    a_fuse_frozen: assert property (p_fuse_frozen)
        else $error("fuse changed while locked");
    c_busy: cover property ($fell(op_progress_flag));
    c_read: cover property ($rose(data_oe));
    c_lock: cover property (protect_mode == 2'h0);
endmodule

// File: testbench/ppp_prog_model.sv
// Purpose: External programmer driving the port pins.
// Assumes: Pins change only at the falling clock edge.
// Notes: The bus is released while output enable is low.
`timescale 1ns/100ps
module ppp_prog_model (
    input wire logic clk_sys,
    output logic load_pulse_pin,
    output logic [1:0] act,
    output logic byte_choice,
    output logic wr_n,
    output logic oe_n,
    output logic [7:0] bus_drv,
    output logic bus_en,
    input wire logic [7:0] bus
);
    initial begin
        load_pulse_pin = 1'b0;
        act = 2'h3;
        byte_choice = 1'b0;
        wr_n = 1'b1;
        oe_n = 1'b1;
        bus_drv = 8'h00;
        bus_en = 1'b1;
    end
    // Codes settle a cycle before the pulse and hold a cycle after.
    task automatic load(input logic [1:0] a, input logic b,
            input logic [7:0] d);
        @(negedge clk_sys) act = a;
        byte_choice = b;
        bus_drv = d;
        @(negedge clk_sys) load_pulse_pin = 1'b1;
        @(negedge clk_sys) load_pulse_pin = 1'b0;
        @(negedge clk_sys) act = 2'h3;
    endtask
    task automatic strobe(input logic b, input int n);
        @(negedge clk_sys) byte_choice = b;
        @(negedge clk_sys) wr_n = 1'b0;
        repeat (n) @(negedge clk_sys);
        wr_n = 1'b1;
    endtask
    task automatic read(input logic b, output logic [7:0] d);
        @(negedge clk_sys) byte_choice = b;
        bus_en = 1'b0;
        oe_n = 1'b0;
        repeat (3) @(negedge clk_sys);
        d = bus;
        oe_n = 1'b1;
        @(negedge clk_sys) bus_en = 1'b1;
    endtask
endmodule

// File: testbench/parallel_program_port_test.sv
// Purpose: Self-checking bench of the parallel programming port.
// Assumes: Busy time shortened to 20 cycles.
// Notes: A small model of arrays, locks and fuses gives the expectations.
`timescale 1ns/100ps
`include "ppp_cfg.svh"
module parallel_program_port_test;
    localparam int WR_CYC = 20;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [1:0] sig_a = 2'h0;
    logic [1:0] lk = 2'h3;
    logic sp = 1'b0;
    logic fs = 1'b1;
    wire pin, bs, wr_n, oe_n, p_en, oe, flag, sd, qs;
    wire [1:0] act, pm;
    wire [7:0] p_drv, d_out, ser_d;
    // A released bus shows the inverse of the last value, not a hold.
    wire [7:0] bus = oe ? d_out : (p_en ? p_drv : ~p_drv);
    int error_cnt = 0;
    int checks_done = 0;
    int fl[int];
    int q[$];
    logic [7:0] ids [3] = '{`PPP_ID0, `PPP_ID1, `PPP_ID2};
    ppp_top #(.WR_CYC(WR_CYC)) i_dut (.clk_sys(clk_sys), .rst(rst),
        .load_pulse_pin(pin), .action_code_low(act[0]),
        .action_code_high(act[1]), .byte_choice(bs), .wr_n(wr_n),
        .oe_n(oe_n), .data_in(bus), .data_out(d_out), .data_oe(oe),
        .op_progress_flag(flag), .ser_sig_addr(sig_a), .ser_sig_data(ser_d),
        .serial_download_en(sd), .quick_startup_sel(qs), .protect_mode(pm));
    ppp_prog_model i_prog (.clk_sys(clk_sys), .load_pulse_pin(pin),
        .act(act), .byte_choice(bs), .wr_n(wr_n), .oe_n(oe_n),
        .bus_drv(p_drv), .bus_en(p_en), .bus(bus));
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic end_sim();
        $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] c);
        i_prog.load(2'h2, 1'b0, c);
    endtask
    task automatic adr(input int a);
        i_prog.load(2'h0, 1'b1, 8'(a >> 8));
        i_prog.load(2'h0, 1'b0, 8'(a));
    endtask
    task automatic put(input int a, input int k, input logic b,
            input logic [7:0] d);
        int n;
        // Erased cells already read as all ones, so that write is skipped.
        if (d == 8'hFF) begin
            return;
        end
        adr(a);
        i_prog.load(2'h1, b, d);
        i_prog.strobe(b, 1);
        chk({7'h00, flag}, {7'h00, lk != 2'h3});
        if (lk == 2'h3) begin
            fl[k] = d;
        end
        for (n = 0; n < 200 && flag !== 1'b1; n++) begin
            @(negedge clk_sys);
        end
        if (flag !== 1'b1) begin
            error_cnt++;
            end_sim();
        end
    endtask
    task automatic get(input int a, input int k, input logic b);
        logic [7:0] d;
        adr(a);
        i_prog.read(b, d);
        chk(d, lk == 2'h0 ? 8'hFF : fl.exists(k) ? 8'(fl[k]) : 8'hFF);
    endtask
    task automatic rd_all();
        cmd(8'h02);
        foreach (q[i]) begin
            get(q[i], q[i] * 2, 1'b0);
            get(q[i], q[i] * 2 + 1, 1'b1);
        end
    endtask
    task automatic fuses();
        chk({6'h00, pm}, {6'h00, lk});
        chk({6'h00, sd, qs}, {6'h00, !sp, !fs});
    endtask
    task automatic bits(input logic [7:0] c, input logic [7:0] d);
        cmd(c);
        i_prog.load(2'h1, 1'b0, d);
        i_prog.strobe(1'b0, 1);
        repeat (2) @(negedge clk_sys);
        if (c == 8'h20) begin
            lk = lk & {d[2], d[1]};
        end else if (lk == 2'h3) begin
            {sp, fs} = {d[5], d[0]};
        end
        fuses();
    endtask
    task automatic rd_bits();
        logic [7:0] d;
        cmd(8'h04);
        i_prog.read(1'b1, d);
        chk(d, {lk[0], lk[1], sp, 4'hF, fs});
        i_prog.read(1'b0, d);
        chk(d, 8'hFF);
        for (int i = 0; i < 3; i++) begin
            sig_a = 2'(i);
            repeat (2) @(negedge clk_sys);
            chk(ser_d, lk == 2'h0 ? 8'(i) : ids[i]);
        end
    endtask
    task automatic erase();
        cmd(8'h80);
        fork
            i_prog.strobe(1'b0, 4100);
            repeat (4100) @(negedge clk_sys) chk({7'h00, flag}, 8'h01);
        join
        repeat (4) @(negedge clk_sys);
        fl.delete();
        lk = 2'h3;
        fuses();
    endtask
    initial begin
        #4000000;
        error_cnt++;
        end_sim();
    end
    initial begin
        logic [31:0] r;
        logic [7:0] d;
        r = 32'h00014619;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys) rst = 1'b0;
        chk({7'h00, flag}, 8'h01);
        fuses();
        rd_bits();
        cmd(8'h08);
        for (int i = 0; i < 3; i++) begin
            adr(i);
            i_prog.read(1'b0, d);
            chk(d, ids[i]);
        end
        i_prog.load(2'h3, 1'b0, 8'h10);
        i_prog.read(1'b0, d);
        chk(d, ids[2]);
        erase();
        q = '{0, 4095};
        repeat (3) begin
            r = lfsr(r);
            q.push_back(int'(r[11:0]));
        end
        cmd(8'h10);
        foreach (q[i]) begin
            r = lfsr(r);
            put(q[i], q[i] * 2, 1'b0, r[7:0]);
            put(q[i], q[i] * 2 + 1, 1'b1, r[15:8]);
        end
        cmd(8'h11);
        put(q[2] & 511, 65536 + (q[2] & 511), 1'b0, r[23:16]);
        cmd(8'h03);
        get(q[2] & 511, 65536 + (q[2] & 511), 1'b0);
        rd_all();
        bits(8'h40, 8'hFE);
        bits(8'h20, 8'hFD);
        bits(8'h40, 8'hFF);
        cmd(8'h10);
        put(q[0], q[0] * 2, 1'b0, 8'h00);
        rd_all();
        bits(8'h20, 8'hFB);
        rd_bits();
        rd_all();
        erase();
        rd_bits();
        rd_all();
        end_sim();
    end
endmodule
bind ppp_top ppp_monitor #(.WR_CYC(WR_CYC)) i_mon (.clk_sys(clk_sys),
    .rst(rst), .wr_n(wr_n), .oe_n(oe_n), .data_out(data_out),
    .data_oe(data_oe), .op_progress_flag(op_progress_flag),
    .ser_sig_addr(ser_sig_addr), .ser_sig_data(ser_sig_data),
    .serial_download_en(serial_download_en),
    .quick_startup_sel(quick_startup_sel), .protect_mode(protect_mode));
